// ### rtl/bcc_pkg.sv
// Shared constants and types of the battery charger control block.
// Assumes one SMBus-style slave link and a single control clock domain.
package bcc_pkg;

  typedef logic [15:0] bcc_word_t;
  typedef logic [7:0]  bcc_byte_t;

  // -------------------------------------------------------------------------
  // Bus addresses and command codes
  // -------------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR7   = 7'h09;
  localparam logic [6:0] ARA_ADDR7   = 7'h0C;
  localparam bcc_byte_t  CMD_CONTROL = 8'h12;
  localparam bcc_byte_t  CMD_FLAGS   = 8'h13;
  localparam bcc_byte_t  CMD_CURRENT = 8'h14;
  localparam bcc_byte_t  CMD_VOLTAGE = 8'h15;
  localparam bcc_byte_t  CMD_ALARM   = 8'h16;
  localparam bcc_byte_t  CMD_VENDOR  = 8'h3C;
  localparam bcc_word_t  RD_UNMAPPED = 16'hFFFF;

  // -------------------------------------------------------------------------
  // Field layouts and reset values
  // -------------------------------------------------------------------------
  localparam bcc_word_t  ALARM_HALT_MASK = 16'hF000;
  localparam int         CTRL_HOLD_BIT   = 0;
  localparam int         VEND_DIS_BIT    = 0;
  localparam int         VEND_VER_LSB    = 4;
  localparam logic [11:0] VERSION_ID     = 12'h0A5;  // Arbitrary value
  localparam logic       VEND_DIS_RST    = 1'b0;
  localparam bcc_word_t  VOLT_MIN_VALID  = 16'h04A0;
  localparam bcc_word_t  IDAC_FULL_SCALE = 16'h1000;
  localparam bcc_word_t  PULSED_LOW_CURRENT_MODE_LIMIT      = IDAC_FULL_SCALE >> 4;
  localparam int         ST_HOLD         = 0;
  localparam int         ST_BLOCKED      = 1;
  localparam int         ST_PWR_FAIL     = 2;
  localparam int         ST_PACK         = 3;
  localparam int         ST_MAINS        = 4;
  localparam int         ST_COLD         = 5;
  localparam int         ST_HOT          = 6;
  localparam int         ST_UNDER        = 7;
  localparam int         ST_OVER         = 8;
  localparam int         ST_WAKE         = 9;
  localparam int         ST_CTRL         = 10;

  // -------------------------------------------------------------------------
  // Timing and states
  // -------------------------------------------------------------------------
  localparam int unsigned WDOG_CYCLES_DEF = 1000000;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000, L_RX = 3'b001, L_ACK = 3'b010, L_TX = 3'b011, L_MACK = 3'b100
  } bcc_link_st_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_WAKE = 2'b01, C_CTRL = 2'b10
  } bcc_ctrl_st_t;

endpackage : bcc_pkg

// ### rtl/bcc_sync_if.sv
// Carrier between a user and its input synchroniser.
// Assumes raw bits come from pins or another clock domain.
`timescale 1ns/100ps
`default_nettype none
interface bcc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport tgt  (input raw, output clean);
  modport user (output raw, input clean);
endinterface : bcc_sync_if
`default_nettype wire

// ### rtl/bcc_sync3.sv
// Three-stage synchroniser with agreement filter.
// Assumes clk is the domain that reads the clean bits.
`timescale 1ns/100ps
`default_nettype none
module bcc_sync3 #(parameter int W = 1) (
  input  wire logic clk,
  bcc_sync_if.tgt   s
);
  logic [W-1:0] f1;
  logic [W-1:0] f2;
  logic [W-1:0] f3;
  logic [W-1:0] clean;
  logic [W-1:0] agree;
  logic [W-1:0] next_clean;

  // Change taken only once stages two and three agree
  always_comb begin
    agree      = ~(f2 ^ f3);
    next_clean = (agree & f3) | (~agree & clean);
  end

  always_ff @(posedge clk) begin
    f1    <= s.raw;
    f2    <= f1;
    f3    <= f2;
    clean <= next_clean;
  end

  assign s.clean = clean;
endmodule : bcc_sync3
`default_nettype wire

// ### rtl/bcc_charger_ctrl.sv
// Battery charger control: bus slave on the link clock, charge sequencing on clk.
// Assumes sense and mains inputs are decoder outputs already on clk.
//
// Notes on behaviour
// - Halt alarm bits block charging, set flag
// - Other alarm bits have no effect
// - Vendor write updates only the pulse-disable bit
// - Pulsed mode below sixteenth scale unless disabled
// - Vendor read returns disable bit and version
// - Answer alert query only while pulling alert
// - Alert query answer carries own address
// - Alert on mains, pack, block, reset
// - Charge alone or by host; alert asks polling
// - Accept commands from any master; alarms act
// - Wake charging needs good sense and mains
// - New pack without both commands starts wake
// - Wake ends on watchdog when cold/underrange
// - Wake ends on fault, mains loss, block, hold
// - Both commands written moves wake to controlled
// - Permit pin low pauses, watchdog keeps running
// - Low supply pauses, watchdog keeps running
// - Controlled start needs nonzero current, voltage at least VOLT_MIN_VALID, sense, mains
// - Controlled stops unless commands refreshed in time
// - Controlled stops on overrange, or on hot without underrange
// - Block clears on rewrite, mains or pack loss
// - Releasing hold resumes with stored values
`timescale 1ns/100ps
`default_nettype none
module bcc_charger_ctrl #(
  parameter int unsigned WDOG_CYCLES = bcc_pkg::WDOG_CYCLES_DEF
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             link_clk,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output var  logic             sda_out,
  output var  logic             sda_oe,
  input  wire logic             alert_in,
  output var  logic             alert_output,
  output var  logic             alert_oe,
  input  wire logic             sense_cold,
  input  wire logic             sense_normal,
  input  wire logic             sense_underrange,
  input  wire logic             sense_overrange,
  input  wire logic             sense_hot,
  input  wire logic             mains_detected,
  input  wire logic             charge_permit_pin,
  input  wire logic             input_supply_ok,
  output var  logic             charge_enable,
  output var  logic             wakeup_active,
  output var  logic             controlled_active,
  output var  logic             pulsed_low_current_mode,
  output var  logic             alarm_charge_blocked,
  output var  bcc_pkg::bcc_word_t charge_current_cmd,
  output var  bcc_pkg::bcc_word_t charge_voltage_cmd
);
  import bcc_pkg::*;

  // -------------------------------------------------------------------------
  // Synchronisers
  // -------------------------------------------------------------------------
  bcc_sync_if #(.W(5)) lsy ();
  bcc_sync_if #(.W(5)) csy ();

  logic      wr_tgl;
  logic      ara_tgl;
  logic      snap_ack;
  logic      snap_req;
  bcc_word_t snap_stat;
  bcc_word_t snap_vend;
  logic      snap_alert;

  assign lsy.raw = {nrst, snap_req, alert_in, sda_in, scl_in};
  assign csy.raw = {snap_ack, ara_tgl, wr_tgl, input_supply_ok, charge_permit_pin};

  bcc_sync3 #(.W(5)) u_lsync (.clk(link_clk), .s(lsy.tgt));
  bcc_sync3 #(.W(5)) u_csync (.clk(clk),      .s(csy.tgt));

  logic lrst_n;
  logic req_s;
  logic alert_s;
  logic sda_s;
  logic scl_s;
  logic ack_s;
  logic ara_s;
  logic wr_s;
  logic supply_s;
  logic permit_s;

  assign {lrst_n, req_s, alert_s, sda_s, scl_s}         = lsy.clean;
  assign {ack_s, ara_s, wr_s, supply_s, permit_s}       = csy.clean;

  // -------------------------------------------------------------------------
  // Link side: byte engine on link_clk
  // -------------------------------------------------------------------------
  bcc_link_st_t lst, next_lst;
  logic [2:0]   bitcnt, next_bit;
  logic [2:0]   bidx, next_bidx;
  bcc_byte_t    sh, next_sh;
  bcc_byte_t    cmd_l, next_cmd;
  bcc_byte_t    lo_l, next_lo;
  bcc_byte_t    txb, next_txb;
  bcc_byte_t    hi_l, next_hi;
  logic         txm, next_txm;
  logic         is_ara, next_ara;
  logic         ackd, next_ackd;
  logic         ack_f, next_ackf;
  logic         more, next_more;
  logic         next_oe;
  logic         scl_q;
  logic         sda_q;
  bcc_byte_t    wr_cmd, next_wcmd;
  bcc_word_t    wr_data, next_wdat;
  logic         next_wtgl;
  logic         next_atgl;
  bcc_word_t    l_stat, next_lstat;
  bcc_word_t    l_vend, next_lvend;
  logic         l_alert, next_lalert;
  logic         next_sack;
  bcc_byte_t    rx_byte;
  bcc_word_t    rd_word;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_c;
  logic         stop_c;

  always_comb begin
    scl_rise    = scl_s & ~scl_q;
    scl_fall    = ~scl_s & scl_q;
    start_c     = scl_s & scl_q & sda_q & ~sda_s;
    stop_c      = scl_s & scl_q & ~sda_q & sda_s;
    rx_byte     = {sh[6:0], sda_s};
    next_lst    = lst;
    next_bit    = bitcnt;
    next_bidx   = bidx;
    next_sh     = sh;
    next_cmd    = cmd_l;
    next_lo     = lo_l;
    next_txb    = txb;
    next_hi     = hi_l;
    next_txm    = txm;
    next_ara    = is_ara;
    next_ackd   = ackd;
    next_ackf   = ack_f;
    next_more   = more;
    next_oe     = sda_oe;
    next_wcmd   = wr_cmd;
    next_wdat   = wr_data;
    next_wtgl   = wr_tgl;
    next_atgl   = ara_tgl;
    next_lstat  = l_stat;
    next_lvend  = l_vend;
    next_lalert = l_alert;
    next_sack   = snap_ack;
    case (cmd_l)
      CMD_FLAGS:  rd_word = l_stat;
      CMD_VENDOR: rd_word = l_vend;
      default:    rd_word = RD_UNMAPPED;
    endcase
    if (req_s != snap_ack) begin
      next_lstat  = snap_stat;
      next_lvend  = snap_vend;
      next_lalert = snap_alert;
      next_sack   = req_s;
    end
    if (start_c) begin
      next_lst  = L_RX;
      next_bit  = 3'h0;
      next_bidx = 3'h0;
      next_oe   = 1'b0;
    end else if (stop_c) begin
      next_lst = L_IDLE;
      next_oe  = 1'b0;
    end else begin
      unique case (lst)
        L_IDLE: begin
        end
        L_RX: if (scl_rise) begin
          next_sh  = rx_byte;
          next_bit = 3'(bitcnt + 3'h1);
          if (bitcnt == 3'h7) begin
            next_lst  = L_ACK;
            next_ackd = 1'b0;
            next_ackf = 1'b1;
            next_txm  = 1'b0;
            next_bidx = (bidx == 3'h4) ? bidx : 3'(bidx + 3'h1);
            case (bidx)
              3'h0: begin
                if (rx_byte == {DEV_ADDR7, 1'b0}) begin
                  next_ara = 1'b0;
                end else if (rx_byte == {DEV_ADDR7, 1'b1}) begin
                  next_ara  = 1'b0;
                  next_txm  = 1'b1;
                  next_more = 1'b1;
                  next_txb  = rd_word[7:0];
                  next_hi   = rd_word[15:8];
                end else if (rx_byte == {ARA_ADDR7, 1'b1} && l_alert && !alert_s) begin
                  next_ara  = 1'b1;
                  next_txm  = 1'b1;
                  next_more = 1'b0;
                  next_txb  = {DEV_ADDR7, 1'b0};
                end else begin
                  next_ackf = 1'b0;
                end
              end
              3'h1: next_cmd = rx_byte;
              3'h2: next_lo  = rx_byte;
              3'h3: begin
                next_wcmd = cmd_l;
                next_wdat = {rx_byte, lo_l};
                next_wtgl = ~wr_tgl;
              end
              default: next_ackf = 1'b0;
            endcase
          end
        end
        L_ACK: if (scl_fall) begin
          if (!ackd) begin
            next_ackd = 1'b1;
            next_oe   = ack_f;
            if (!ack_f) begin
              next_lst = L_IDLE;
            end
          end else if (txm) begin
            next_lst = L_TX;
            next_bit = 3'h0;
            next_oe  = ~txb[7];
          end else begin
            next_lst = L_RX;
            next_bit = 3'h0;
            next_oe  = 1'b0;
          end
        end
        L_TX: if (scl_rise && !sda_oe && !sda_s) begin
          next_lst = L_IDLE;
        end else if (scl_fall) begin
          if (bitcnt == 3'h7) begin
            next_oe  = 1'b0;
            next_lst = L_MACK;
            if (is_ara) begin
              next_atgl = ~ara_tgl;
            end
          end else begin
            next_bit = 3'(bitcnt + 3'h1);
            next_txb = {txb[6:0], 1'b0};
            next_oe  = ~txb[6];
          end
        end
        L_MACK: if (scl_rise) begin
          next_ackf = ~sda_s & more;
          next_more = 1'b0;
          if (!sda_s && more) begin
            next_txb = hi_l;
          end
        end else if (scl_fall) begin
          next_lst = ack_f ? L_TX : L_IDLE;
          next_bit = 3'h0;
          next_oe  = ack_f & ~txb[7];
        end
        default: next_lst = L_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      lst      <= L_IDLE;
      bitcnt   <= 3'h0;
      bidx     <= 3'h0;
      sh       <= 8'h00;
      cmd_l    <= 8'h00;
      lo_l     <= 8'h00;
      txb      <= 8'h00;
      hi_l     <= 8'h00;
      txm      <= 1'b0;
      is_ara   <= 1'b0;
      ackd     <= 1'b0;
      ack_f    <= 1'b0;
      more     <= 1'b0;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      wr_cmd   <= 8'h00;
      wr_data  <= 16'h0000;
      wr_tgl   <= 1'b0;
      ara_tgl  <= 1'b0;
      l_stat   <= 16'h0000;
      l_vend   <= 16'h0000;
      l_alert  <= 1'b0;
      snap_ack <= 1'b0;
    end else begin
      lst      <= next_lst;
      bitcnt   <= next_bit;
      bidx     <= next_bidx;
      sh       <= next_sh;
      cmd_l    <= next_cmd;
      lo_l     <= next_lo;
      txb      <= next_txb;
      hi_l     <= next_hi;
      txm      <= next_txm;
      is_ara   <= next_ara;
      ackd     <= next_ackd;
      ack_f    <= next_ackf;
      more     <= next_more;
      sda_oe   <= next_oe;
      sda_out  <= 1'b0;
      scl_q    <= scl_s;
      sda_q    <= sda_s;
      wr_cmd   <= next_wcmd;
      wr_data  <= next_wdat;
      wr_tgl   <= next_wtgl;
      ara_tgl  <= next_atgl;
      l_stat   <= next_lstat;
      l_vend   <= next_lvend;
      l_alert  <= next_lalert;
      snap_ack <= next_sack;
    end
  end

  // -------------------------------------------------------------------------
  // Control side: commands, alert and charge sequencing on clk
  // -------------------------------------------------------------------------
  bcc_ctrl_st_t cst, next_cst;
  bcc_word_t    next_cur, next_vol;
  logic         hold, next_hold;
  logic         dis, next_dis;
  logic         next_blk;
  logic         got_cur, next_gcur;
  logic         got_vol, next_gvol;
  logic         armed, next_armed;
  logic [31:0]  wdog, next_wdog;
  logic         next_alert;
  logic         mains_q;
  logic         pack_q;
  logic         wr_seen;
  logic         ara_seen;
  bcc_word_t    next_sstat;
  bcc_word_t    next_svend;
  logic         next_salert;
  logic         next_sreq;
  logic         next_chg;
  bcc_word_t    stat_w;
  logic         pack;
  logic         sense_ok;
  logic         hot_only;
  logic         wdog_exp;
  logic         wr_new;
  logic         cur_hit;
  logic         vol_hit;
  logic         alarm_hit;
  logic         pair;
  logic         mains_chg;
  logic         pack_chg;
  logic         ctrl_ready;
  logic         wake_ok;

  always_comb begin
    pack      = ~sense_overrange;
    hot_only  = sense_hot & ~sense_underrange;
    sense_ok  = pack & ~hot_only & (sense_cold | sense_normal | sense_underrange);
    wdog_exp  = (wdog >= WDOG_CYCLES);
    wr_new    = (wr_s != wr_seen);
    cur_hit   = wr_new && (wr_cmd == CMD_CURRENT);
    vol_hit   = wr_new && (wr_cmd == CMD_VOLTAGE);
    alarm_hit = wr_new && (wr_cmd == CMD_ALARM) && |(wr_data & ALARM_HALT_MASK);
    pair      = (got_cur | cur_hit) & (got_vol | vol_hit);
    mains_chg = mains_detected ^ mains_q;
    pack_chg  = pack ^ pack_q;
    next_cst    = cst;
    next_cur    = cur_hit ? wr_data : charge_current_cmd;
    next_vol    = vol_hit ? wr_data : charge_voltage_cmd;
    next_hold   = hold;
    next_dis    = dis;
    next_gcur   = got_cur | cur_hit;
    next_gvol   = got_vol | vol_hit;
    next_armed  = armed;
    next_wdog   = wdog_exp ? wdog : wdog + 32'h1;
    if (wr_new && wr_cmd == CMD_CONTROL) begin
      next_hold = wr_data[CTRL_HOLD_BIT];
    end
    if (wr_new && wr_cmd == CMD_VENDOR) begin
      next_dis = wr_data[VEND_DIS_BIT];
    end
    if (pair) begin
      next_gcur  = 1'b0;
      next_gvol  = 1'b0;
      next_wdog  = 32'h0;
      next_armed = 1'b0;
    end
    if (pack & ~pack_q) begin
      next_armed = 1'b1;
      next_wdog  = 32'h0;
    end
    if (!pack) begin
      next_cur  = 16'h0000;
      next_vol  = 16'h0000;
      next_gcur = 1'b0;
      next_gvol = 1'b0;
    end
    next_blk = alarm_hit | (alarm_charge_blocked &
               ~(pair | (mains_q & ~mains_detected) | ~pack));
    next_alert = mains_chg | pack_chg | (alarm_hit & ~alarm_charge_blocked)
               | (alert_oe & ~(ara_s != ara_seen));
    ctrl_ready = (next_cur != 16'h0000) && (next_vol >= VOLT_MIN_VALID)
               && sense_ok && mains_detected && !next_blk && !next_hold
               && !wdog_exp;
    wake_ok    = sense_ok && mains_detected && !next_blk && !next_hold;
    unique case (cst)
      C_IDLE: begin
        if (ctrl_ready) begin
          next_cst = C_CTRL;
        end else if (armed && wake_ok && !pair) begin
          next_cst = C_WAKE;
        end
      end
      C_WAKE: begin
        if (pair) begin
          next_cst = ctrl_ready ? C_CTRL : C_IDLE;
        end else if (wdog_exp && (sense_cold || sense_underrange)) begin
          next_cst   = C_IDLE;
          next_armed = 1'b0;
        end else if (!wake_ok) begin
          next_cst   = C_IDLE;
          next_armed = 1'b0;
        end
      end
      C_CTRL: begin
        if (!ctrl_ready || sense_overrange || hot_only) begin
          next_cst = C_IDLE;
        end
      end
      default: next_cst = C_IDLE;
    endcase
    next_chg = (next_cst != C_IDLE) && permit_s && supply_s;
    stat_w              = 16'h0000;
    stat_w[ST_HOLD]     = hold;
    stat_w[ST_BLOCKED]  = alarm_charge_blocked;
    stat_w[ST_PWR_FAIL] = ~(permit_s & supply_s);
    stat_w[ST_PACK]     = pack;
    stat_w[ST_MAINS]    = mains_detected;
    stat_w[ST_COLD]     = sense_cold;
    stat_w[ST_HOT]      = sense_hot;
    stat_w[ST_UNDER]    = sense_underrange;
    stat_w[ST_OVER]     = sense_overrange;
    stat_w[ST_WAKE]     = wakeup_active;
    stat_w[ST_CTRL]     = controlled_active;
    next_sstat  = snap_stat;
    next_svend  = snap_vend;
    next_salert = snap_alert;
    next_sreq   = snap_req;
    if (ack_s == snap_req) begin
      next_sstat  = stat_w;
      next_svend  = {VERSION_ID, 4'h0} | (16'h1 << VEND_DIS_BIT) & {16{dis}};
      next_salert = alert_oe;
      next_sreq   = ~snap_req;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cst                     <= C_IDLE;
      charge_current_cmd      <= 16'h0000;
      charge_voltage_cmd      <= 16'h0000;
      hold                    <= 1'b0;
      dis                     <= VEND_DIS_RST;
      alarm_charge_blocked    <= 1'b0;
      got_cur                 <= 1'b0;
      got_vol                 <= 1'b0;
      armed                   <= 1'b0;
      wdog                    <= 32'h0;
      alert_oe                <= 1'b1;
      alert_output            <= 1'b0;
      mains_q                 <= 1'b0;
      pack_q                  <= 1'b0;
      wr_seen                 <= 1'b0;
      ara_seen                <= 1'b0;
      snap_stat               <= 16'h0000;
      snap_vend               <= 16'h0000;
      snap_alert              <= 1'b0;
      snap_req                <= 1'b0;
      charge_enable           <= 1'b0;
      wakeup_active           <= 1'b0;
      controlled_active       <= 1'b0;
      pulsed_low_current_mode <= 1'b0;
    end else begin
      cst                     <= next_cst;
      charge_current_cmd      <= next_cur;
      charge_voltage_cmd      <= next_vol;
      hold                    <= next_hold;
      dis                     <= next_dis;
      alarm_charge_blocked    <= next_blk;
      got_cur                 <= next_gcur;
      got_vol                 <= next_gvol;
      armed                   <= next_armed;
      wdog                    <= next_wdog;
      alert_oe                <= next_alert;
      alert_output            <= 1'b0;
      mains_q                 <= mains_detected;
      pack_q                  <= pack;
      wr_seen                 <= wr_s;
      ara_seen                <= ara_s;
      snap_stat               <= next_sstat;
      snap_vend               <= next_svend;
      snap_alert              <= next_salert;
      snap_req                <= next_sreq;
      charge_enable           <= next_chg;
      wakeup_active           <= (next_cst == C_WAKE);
      controlled_active       <= (next_cst == C_CTRL);
      pulsed_low_current_mode <= next_chg && !next_dis && (next_cur != 16'h0000)
                                 && (next_cur < PULSED_LOW_CURRENT_MODE_LIMIT);
    end
  end

endmodule : bcc_charger_ctrl
`default_nettype wire

// ### tb/bcc_host_model.sv
// Bus master model: host or battery on the far side.
// Assumes an SDA pull-up; the bench forms the wired-AND.
`timescale 1ns/100ps
`default_nettype none
module bcc_host_model (
  input  wire logic       sda_in,
  output var  logic       scl_o,
  output var  logic       sda_o,
  output var  logic [8:0] rx
);
  initial begin
    {scl_o, sda_o, rx} = 11'h7FF;
  end
  // Nine bits, last one the ack slot
  task automatic tx(input logic [8:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda_o = b[i];
      #600 scl_o = 1'b1;
      #600 rx[i] = sda_in;
      #600 scl_o = 1'b0;
      #600;
    end
  endtask : tx
  task automatic start();
    sda_o = 1'b0;
    #1200 scl_o = 1'b0;
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    #600 scl_o = 1'b1;
    #1200 sda_o = 1'b1;
    #1200;
  endtask : stop
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    start();
    tx(9'h025);
    tx({c, 1'b1});
    tx({w[7:0], 1'b1});
    tx({w[15:8], 1'b1});
    stop();
  endtask : wr
  // Read word: command, repeated start, two bytes
  task automatic rd(input logic [7:0] c, output logic [15:0] w);
    start();
    tx(9'h025);
    tx({c, 1'b1});
    sda_o = 1'b1;
    #600 scl_o = 1'b1;
    #600 start();
    tx(9'h027);
    tx(9'h1FE);
    w[7:0] = rx[8:1];
    tx(9'h1FF);
    w[15:8] = rx[8:1];
    stop();
  endtask : rd
endmodule : bcc_host_model
`default_nettype wire

// ### tb/bcc_charger_ctrl_asserts.sv
// Checker on the charger control ports.
// Assumes it is bound to the top module.
`timescale 1ns/100ps
`default_nettype none
module bcc_charger_ctrl_asserts (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        alert_oe,
  input wire logic        sense_overrange,
  input wire logic        mains_detected,
  input wire logic        charge_enable,
  input wire logic        wakeup_active,
  input wire logic        controlled_active,
  input wire logic        pulsed_low_current_mode,
  input wire logic        alarm_charge_blocked,
  input wire logic [15:0] charge_current_cmd
);
  import bcc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic md = wakeup_active || controlled_active;
  wire logic lo = charge_current_cmd != 16'h0000 && charge_current_cmd < PULSED_LOW_CURRENT_MODE_LIMIT;
  AST_PULSED_LOW_CURRENT_MODE: assert property (pulsed_low_current_mode |-> lo || $past(lo)) else $error("pulsed_low_current_mode");
  AST_ONE: assert property (!(wakeup_active && controlled_active)) else $error("modes");
  AST_EN: assert property (charge_enable |-> md || $past(md)) else $error("no mode");
  AST_OVR: assert property (sense_overrange [*2] |-> !md) else $error("overrange");
  AST_MNS: assert property (!mains_detected [*2] |-> !charge_enable) else $error("mains");
  AST_BLK: assert property (alarm_charge_blocked [*2] |-> !charge_enable) else $error("blk");
  AST_BAL: assert property ($rose(alarm_charge_blocked) |-> ##[0:2] alert_oe) else $error("ba");
  AST_MAL: assert property ($changed(mains_detected) |-> ##[1:3] alert_oe) else $error("ma");
  cover property ($rose(controlled_active));
  cover property ($rose(pulsed_low_current_mode));
  cover property ($rose(alarm_charge_blocked));
endmodule : bcc_charger_ctrl_asserts
bind bcc_charger_ctrl bcc_charger_ctrl_asserts u_chk (.*);
`default_nettype wire

// ### tb/tb.sv
// Bench: bus writes, alert queries and pin changes.
// Assumes the host model is the only bus master.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bcc_pkg::*;
  localparam int WD = 8000;
  logic clk, link_clk, nrst, a, sda_h, scl_in;
  logic sense_cold, sense_normal, sense_underrange, sense_overrange, sense_hot;
  logic mains_detected, charge_permit_pin, input_supply_ok, sda_out, sda_oe;
  logic alert_output, alert_oe, charge_enable, wakeup_active, controlled_active;
  logic pulsed_low_current_mode, alarm_charge_blocked;
  logic [8:0] rx;
  bcc_word_t charge_current_cmd, charge_voltage_cmd;
  bcc_word_t rw;
  int errors = 0, tests_run = 0, cycles = 0;
  wire logic sda_in = sda_h & ~sda_oe;
  wire logic alert_in = ~alert_oe;
  bcc_host_model host (.sda_in(sda_in), .scl_o(scl_in), .sda_o(sda_h), .rx(rx));
  bcc_charger_ctrl #(.WDOG_CYCLES(WD)) dut (.*);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input logic ok);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t check %0d", $time, tests_run);
    end
  endtask : chk
  task automatic pins(input logic [7:0] v, input int n);
    {sense_hot, sense_overrange, sense_underrange, sense_normal, sense_cold,
     mains_detected, charge_permit_pin, input_supply_ok} = v;
    repeat (n) @(negedge clk);
  endtask : pins
  task automatic wr(input bcc_byte_t c, input bcc_word_t w);
    host.wr(c, w);
    repeat (10) @(negedge clk);
  endtask : wr
  task automatic ara(output logic ack);
    host.start();
    host.tx({ARA_ADDR7, 2'b11});
    ack = ~rx[0];
    host.tx(9'h1FF);
    host.stop();
    repeat (10) @(negedge clk);
  endtask : ara
  initial begin
    nrst = 1'b0;
    pins(8'h4F, 20);
    nrst = 1'b1;
    repeat (20) @(negedge clk);
    ara(a);
    chk(a === 1'b1 && rx[8:1] === 8'h12 && alert_oe === 1'b0);
    ara(a);
    chk(a === 1'b0);
    pins(8'h17, 10);
    chk(wakeup_active === 1'b1 && charge_enable === 1'b1 && alert_oe === 1'b1);
    ara(a);
    for (int i = 0; i < 2; i++) begin
      pins(8'h15 + 8'(i), 10);
      chk(charge_enable === 1'b0 && wakeup_active === 1'b1);
      pins(8'h17, 10);
      chk(charge_enable === 1'b1);
    end
    $display("done: alert and wake-up");
    wr(CMD_CURRENT, 16'h0080);
    wr(CMD_VOLTAGE, 16'h1000);
    chk(controlled_active === 1'b1 && pulsed_low_current_mode === 1'b1);
    wr(CMD_VENDOR, 16'hFFFF);
    chk(pulsed_low_current_mode === 1'b0);
    host.rd(CMD_VENDOR, rw);
    chk(rw === {VERSION_ID, 3'h0, 1'b1});
    wr(CMD_VENDOR, 16'hFFFE);
    chk(pulsed_low_current_mode === 1'b1);
    wr(CMD_ALARM, 16'h0FFF);
    chk(alarm_charge_blocked === 1'b0 && charge_enable === 1'b1);
    for (int i = 12; i < 16; i++) begin
      wr(CMD_ALARM, bcc_word_t'(1 << i));
      chk(alarm_charge_blocked === 1'b1 && charge_enable === 1'b0 && alert_oe === 1'b1);
      wr(CMD_CURRENT, 16'h0200);
      wr(CMD_VOLTAGE, 16'h1000);
      chk(alarm_charge_blocked === 1'b0 && controlled_active === 1'b1);
    end
    $display("done: commands");
    pins(8'h87, 10);
    chk(controlled_active === 1'b0);
    pins(8'h17, 10);
    wr(CMD_CONTROL, 16'h0001);
    chk(controlled_active === 1'b0);
    wr(CMD_CONTROL, 16'h0000);
    chk(controlled_active === 1'b1 && charge_current_cmd === 16'h0200);
    repeat (WD) @(negedge clk);
    chk(controlled_active === 1'b0);
    pins(8'h4B, 10);
    chk(charge_current_cmd === 16'h0000 && charge_voltage_cmd === 16'h0000 && alert_oe === 1'b1);
    pins(8'h0F, 10);
    chk(wakeup_active === 1'b1);
    repeat (WD) @(negedge clk);
    chk(wakeup_active === 1'b0 && charge_enable === 1'b0);
    $display("done: stop conditions");
    summarize();
  end
endmodule : tb
`default_nettype wire
